// ### sadc_pkg.sv
// constants and types for the converter control block
package sadc_pkg;
   // byte addresses of the software registers
   localparam logic [7:0] SADC_CTRL_ADDR   = 8'h00;
   localparam logic [7:0] SADC_RESH_ADDR   = 8'h04;
   localparam logic [7:0] SADC_AUX_ADDR    = 8'h08;
   localparam logic [7:0] SADC_PWR_ADDR    = 8'h0c;
   localparam logic [7:0] SADC_IRQST_ADDR  = 8'h10;
   localparam logic [7:0] SADC_IRQEN_ADDR  = 8'h14;
   localparam logic [7:0] SADC_IRQCLR_ADDR = 8'h18;
   // conversion_control fields
   localparam int SADC_CH_LSB     = 0;
   localparam int SADC_START_BIT  = 3;
   localparam int SADC_DONE_BIT   = 4;
   localparam int SADC_EXTEN_BIT  = 5;
   localparam int SADC_RES0_BIT   = 6;
   localparam int SADC_RES1_BIT   = 7;
   // auxiliary_control and power_control fields
   localparam int SADC_IDLE_RUN_BIT = 6;
   localparam int SADC_IDLE_BIT     = 0;
   localparam int SADC_PD_BIT       = 1;
   // interrupt status bits
   localparam int SADC_IRQ_DONE  = 0;
   localparam int SADC_IRQ_ABORT = 1;
   localparam int SADC_IRQ_W     = 2;
   // timing in machine cycles (one clock each)
   localparam int SADC_CONV_CYCLES   = 50;
   localparam int SADC_INIT_CYCLES   = 2;
   localparam int SADC_SAMPLE_CYCLES = 8;
   localparam int SADC_BIT_CYCLES    = 4;
   localparam int SADC_RES_W         = 10;
   localparam logic [5:0] SADC_CNT_LAST = 6'(SADC_CONV_CYCLES - 1);
   localparam logic [9:0] SADC_RES_RESET = 10'h000;
   localparam logic [1:0] SADC_HTRANS_NONSEQ = 2'h2;
   typedef enum logic [1:0] {SADC_IDLE, SADC_INIT, SADC_SAMPLE, SADC_APPROX}
      sadc_state_type;
endpackage

// ### sadc_sar.sv
// successive approximation register and bit pointer
`timescale 1ns/1ps
`default_nettype none
module sadc_sar
   import sadc_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  clear,
   input  wire logic                  load_first,
   input  wire logic                  decide,
   input  wire logic                  comp_high,
   output logic      [SADC_RES_W-1:0] trial,
   output logic                       last_bit
);
   logic [SADC_RES_W-1:0] value_r;
   logic [SADC_RES_W-1:0] ptr_r;
   logic [SADC_RES_W-1:0] kept;
   // keep the tested bit only when the input lies above the dac tap
   assign kept     = comp_high ? value_r : (value_r & ~ptr_r);
   assign trial    = value_r;
   assign last_bit = ptr_r[0];
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         value_r <= SADC_RES_RESET;
         ptr_r   <= SADC_RES_RESET;
      end else if (clear) begin
         value_r <= SADC_RES_RESET;
         ptr_r   <= SADC_RES_RESET;
      end else if (load_first) begin
         value_r <= 10'h200;
         ptr_r   <= 10'h200;
      end else if (decide) begin
         value_r <= kept | (ptr_r >> 1);
         ptr_r   <= ptr_r >> 1;
      end
   end
endmodule
`default_nettype wire

// ### sadc_top.sv
// converter control block with ahb-lite register slave
//
// The AHB-Lite interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - software start is ignored while busy or done flag is high
// - no new conversion while done flag set; software clears it first
// - inputs below first tap give result 000h
// - inputs above last tap give result 3ffh
// - result is 1024 times input over reference span
// - idle stops the converter unless idle-run enable is set
// - power-down halts all converter activity until left
// - external-start enable adds pin rising edge as start source
// - done set, busy cleared fifty cycles after start command
// - upper eight result bits in result_high, two lsbs in control
// - idle without idle-run, or power-down, aborts conversion; finished result survives
module sadc_top
   import sadc_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RESET_N,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        EXTERNAL_START_PIN,
   input  wire logic        COMP_HIGH,
   output logic      [2:0]  ANALOG_INPUT_SEL,
   output logic      [9:0]  DAC_CODE,
   output logic             SAMPLE_EN,
   output logic             IRQ
);
   // address phase capture
   logic        wr_pend_r;
   logic [7:0]  addr_r;
   logic        ap_valid;
   logic        ap_write;
   logic        ap_read;
   // software registers
   logic [2:0]  channel_r;
   logic        ext_en_r;
   logic        done_r;
   logic        cmd_r;
   logic        busy_r;
   logic [9:0]  result_r;
   logic        idle_run_r;
   logic        idle_r;
   logic        pd_r;
   logic [SADC_IRQ_W-1:0] irq_st_r;
   logic [SADC_IRQ_W-1:0] irq_en_r;
   logic [31:0] rdata_r;
   logic        pin_d_r;
   // conversion engine
   sadc_state_type state_r;
   sadc_state_type state_nxt;
   logic [5:0]  cnt_r;
   logic [3:0]  sub_r;
   logic [31:0] rdata_nxt;
   // decode of the data-phase write
   wire         wr_ctrl   = wr_pend_r && (addr_r == SADC_CTRL_ADDR);
   wire         wr_aux    = wr_pend_r && (addr_r == SADC_AUX_ADDR);
   wire         wr_pwr    = wr_pend_r && (addr_r == SADC_PWR_ADDR);
   wire         wr_irqen  = wr_pend_r && (addr_r == SADC_IRQEN_ADDR);
   wire         wr_irqclr = wr_pend_r && (addr_r == SADC_IRQCLR_ADDR);
   wire         sw_start  = wr_ctrl && HWDATA[SADC_START_BIT];
   wire         hw_start  = ext_en_r && EXTERNAL_START_PIN && !pin_d_r;
   wire         blocked   = busy_r || done_r || cmd_r;
   // idle halts unless idle-run set; power-down halts always
   wire         halted    = pd_r || (idle_r && !idle_run_r);
   wire         start_ok  = (sw_start || hw_start) && !blocked && !halted;
   wire         running   = (state_r != SADC_IDLE);
   wire         abort     = running && halted;
   wire         sar_load  = (state_r == SADC_SAMPLE) &&
                            (cnt_r == 6'(SADC_INIT_CYCLES +
                                          SADC_SAMPLE_CYCLES - 1));
   wire         bit_tick  = (state_r == SADC_APPROX) &&
                            (sub_r == 4'(SADC_BIT_CYCLES - 1));
   wire         finish    = (state_r == SADC_APPROX) &&
                            (cnt_r == SADC_CNT_LAST);
   wire         sar_last;
   wire [9:0]   sar_trial;
   wire         sar_decide = bit_tick && !finish;

   function automatic logic is_map(input logic [7:0] a);
      is_map = (a == SADC_CTRL_ADDR) || (a == SADC_RESH_ADDR) ||
               (a == SADC_AUX_ADDR) || (a == SADC_PWR_ADDR) ||
               (a == SADC_IRQST_ADDR) || (a == SADC_IRQEN_ADDR) ||
               (a == SADC_IRQCLR_ADDR);
   endfunction

   assign ap_valid  = HSEL && HREADY && HTRANS[1];
   assign ap_write  = ap_valid && HWRITE && is_map(HADDR[7:0]);
   assign ap_read   = ap_valid && !HWRITE;
   assign HREADYOUT = 1'b1;
   assign HRESP     = 1'b0;
   assign HRDATA    = rdata_r;
   assign IRQ       = |(irq_st_r & irq_en_r);
   assign ANALOG_INPUT_SEL = channel_r;
   assign DAC_CODE  = sar_trial;
   assign SAMPLE_EN = (state_r == SADC_SAMPLE);

   // the ladder taps sit at half and one-and-half lsb from the rails, so
   // code k is kept when vin exceeds tap k; this yields 000h and 3ffh at the
   // ends and 1024*(vin-vref-)/span in between
   sadc_sar u_sar (
      .clk        (CLK_SYS),
      .rst_n      (RESET_N),
      .clear      (start_ok || abort),
      .load_first (sar_load),
      .decide     (sar_decide),
      .comp_high  (COMP_HIGH),
      .trial      (sar_trial),
      .last_bit   (sar_last)
   );

   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         SADC_IDLE:   if (cmd_r && !halted) state_nxt = SADC_INIT;
         SADC_INIT:   if (cnt_r == 6'(SADC_INIT_CYCLES - 1))
                         state_nxt = SADC_SAMPLE;
         SADC_SAMPLE: if (sar_load) state_nxt = SADC_APPROX;
         SADC_APPROX: if (finish) state_nxt = SADC_IDLE;
      endcase
      if (abort) state_nxt = SADC_IDLE;
   end

   always_comb begin
      rdata_nxt = 32'h0000_0000;
      unique case (HADDR[7:0])
         SADC_CTRL_ADDR:  rdata_nxt[7:0] = {result_r[1:0], ext_en_r, done_r,
                                            busy_r, channel_r};
         SADC_RESH_ADDR:  rdata_nxt[7:0] = result_r[9:2];
         SADC_AUX_ADDR:   rdata_nxt[SADC_IDLE_RUN_BIT] = idle_run_r;
         SADC_PWR_ADDR:   rdata_nxt[1:0] = {pd_r, idle_r};
         SADC_IRQST_ADDR: rdata_nxt[SADC_IRQ_W-1:0] = irq_st_r;
         SADC_IRQEN_ADDR: rdata_nxt[SADC_IRQ_W-1:0] = irq_en_r;
         default:         rdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         wr_pend_r <= 1'b0;
         addr_r    <= 8'h00;
         rdata_r   <= 32'h0000_0000;
      end else begin
         wr_pend_r <= ap_write;
         addr_r    <= HADDR[7:0];
         if (ap_read) rdata_r <= rdata_nxt;
      end
   end

   // next values of the software-written registers
   logic [2:0]  channel_nxt;
   logic        ext_en_nxt;
   logic        idle_run_nxt;
   logic        idle_nxt;
   logic        pd_nxt;
   logic [SADC_IRQ_W-1:0] irq_en_nxt;
   // next values of the conversion engine
   logic        cmd_nxt;
   logic        busy_nxt;
   logic        done_nxt;
   logic [9:0]  result_nxt;
   logic [5:0]  cnt_nxt;
   logic [3:0]  sub_nxt;
   wire  [SADC_IRQ_W-1:0] irq_event;
   wire  [SADC_IRQ_W-1:0] irq_st_nxt;
   // busy shows from the end of the first machine cycle of a command
   wire         busy_set   = (state_r == SADC_IDLE) && cmd_r && !halted;
   wire         done_clr   = wr_ctrl && !HWDATA[SADC_DONE_BIT];
   // the tenth bit is decided in the very cycle that stores the result
   wire         last_low   = sar_last && !COMP_HIGH;
   wire [9:0]   final_code = sar_trial & ~{9'h000, last_low};

   always_comb begin
      channel_nxt = channel_r;
      ext_en_nxt  = ext_en_r;
      if (wr_ctrl) begin
         channel_nxt = HWDATA[SADC_CH_LSB +: 3];
         ext_en_nxt  = HWDATA[SADC_EXTEN_BIT];
      end
   end

   always_comb begin
      idle_run_nxt = idle_run_r;
      idle_nxt     = idle_r;
      pd_nxt       = pd_r;
      irq_en_nxt   = irq_en_r;
      if (wr_aux) idle_run_nxt = HWDATA[SADC_IDLE_RUN_BIT];
      if (wr_pwr) begin
         idle_nxt = HWDATA[SADC_IDLE_BIT];
         pd_nxt   = HWDATA[SADC_PD_BIT];
      end
      if (wr_irqen) irq_en_nxt = HWDATA[SADC_IRQ_W-1:0];
   end

   // command flip-flop and status flag are kept apart
   always_comb begin
      cmd_nxt = cmd_r;
      if (start_ok) cmd_nxt = 1'b1;
      else if (state_r == SADC_INIT || abort) cmd_nxt = 1'b0;
   end

   always_comb begin
      busy_nxt = busy_r;
      if (busy_set) busy_nxt = 1'b1;
      else if (finish || abort) busy_nxt = 1'b0;
   end

   // set wins over a same-cycle software clear; software cannot set
   always_comb begin
      done_nxt = done_r;
      if (finish) done_nxt = 1'b1;
      else if (done_clr) done_nxt = 1'b0;
   end

   always_comb begin
      result_nxt = result_r;
      if (finish) result_nxt = final_code;
   end

   // the count starts with the command, so done lands fifty cycles on
   always_comb begin
      cnt_nxt = cnt_r + 6'h01;
      if (state_r == SADC_IDLE) cnt_nxt = 6'(busy_set);
      else if (abort || finish) cnt_nxt = 6'h00;
   end

   always_comb begin
      sub_nxt = sub_r + 4'h1;
      if (state_r != SADC_APPROX || bit_tick) sub_nxt = 4'h0;
   end

   // each status bit: the hardware event wins over a same-cycle clear
   assign irq_event[SADC_IRQ_DONE]  = finish;
   assign irq_event[SADC_IRQ_ABORT] = abort;
   for (genvar g = 0; g < SADC_IRQ_W; g++) begin : g_irq
      assign irq_st_nxt[g] = irq_event[g] ||
                             (irq_st_r[g] && !(wr_irqclr && HWDATA[g]));
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         channel_r <= 3'h0;
         ext_en_r  <= 1'b0;
      end else begin
         channel_r <= channel_nxt;
         ext_en_r  <= ext_en_nxt;
      end
   end

   // pin history resets to the idle level, so no false edge after reset
   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         pin_d_r <= 1'b0;
      end else begin
         pin_d_r <= EXTERNAL_START_PIN;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         idle_run_r <= 1'b0;
         idle_r     <= 1'b0;
         pd_r       <= 1'b0;
      end else begin
         idle_run_r <= idle_run_nxt;
         idle_r     <= idle_nxt;
         pd_r       <= pd_nxt;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         irq_en_r <= '0;
         irq_st_r <= '0;
      end else begin
         irq_en_r <= irq_en_nxt;
         irq_st_r <= irq_st_nxt;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         cmd_r  <= 1'b0;
         busy_r <= 1'b0;
      end else begin
         cmd_r  <= cmd_nxt;
         busy_r <= busy_nxt;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         done_r   <= 1'b0;
         result_r <= SADC_RES_RESET;
      end else begin
         done_r   <= done_nxt;
         result_r <= result_nxt;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         state_r <= SADC_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RESET_N) begin
      if (!RESET_N) begin
         cnt_r <= 6'h00;
         sub_r <= 4'h0;
      end else begin
         cnt_r <= cnt_nxt;
         sub_r <= sub_nxt;
      end
   end
endmodule
`default_nettype wire

// ### sadc_checker.sv
// port-level assertions for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sadc_checker
   import sadc_pkg::*;
(
   input  wire logic        CLK_SYS,
   input  wire logic        RESET_N,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic        HREADY,
   input  wire logic [31:0] HRDATA,
   input  wire logic        HREADYOUT,
   input  wire logic        HRESP,
   input  wire logic [2:0]  ANALOG_INPUT_SEL,
   input  wire logic [9:0]  DAC_CODE,
   input  wire logic        SAMPLE_EN
);
   logic       rd_dp_r;
   logic [7:0] rd_addr_r;
   wire        rd_req = HSEL & HREADY & HTRANS[1] & ~HWRITE;
   wire        rd_ctrl = rd_dp_r && rd_addr_r == SADC_CTRL_ADDR;
   wire        rd_resh = rd_dp_r && rd_addr_r == SADC_RESH_ADDR;
   // no reset needed: every use is masked while reset is low
   always_ff @(posedge CLK_SYS) begin
      rd_dp_r <= rd_req;
      rd_addr_r <= HADDR[7:0];
   end
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RESET_N);
   sequence s_sample;
      SAMPLE_EN [*8] ##1 !SAMPLE_EN;
   endsequence
   a_bus_okay: assert property (HREADYOUT && !HRESP)
      else $error("bus answer not ready okay");
   a_sample_window: assert property ($rose(SAMPLE_EN) |-> s_sample)
      else $error("sample window not eight cycles");
   a_no_resample: assert property ($fell(SAMPLE_EN) |=> !SAMPLE_EN [*8])
      else $error("sampling restarted during conversion");
   a_first_trial: assert property ($fell(SAMPLE_EN) |-> ##[0:1] DAC_CODE == 10'h200)
      else $error("first trial code is not midscale");
   a_chan_hold: assert property (SAMPLE_EN |-> $stable(ANALOG_INPUT_SEL))
      else $error("channel moved while sampling");
   a_unmapped_zero: assert property (rd_dp_r && rd_addr_r > 8'h18 |-> HRDATA == 32'h0)
      else $error("unmapped read not zero");
   a_busy_done_excl: assert property (rd_ctrl |-> !(HRDATA[3] && HRDATA[4]))
      else $error("busy and done read high together");
   a_result_width: assert property (rd_resh |-> HRDATA[31:8] == 24'h0)
      else $error("result high has stray upper bits");
endmodule
`default_nettype wire

// ### sadc_ladder_model.sv
// resistor ladder and comparator model on the converter's analog side
`timescale 1ns/1ps
`default_nettype none
module sadc_ladder_model (
   input  wire logic [2:0] sel,
   input  wire logic [9:0] code,
   output logic            comp_high
);
   // channel inputs in half-lsb steps above the lower reference
   int unsigned vin2 [8];
   // tap of code c sits half a step below c: first tap 0.5, last 1.5 short
   always_comb begin
      comp_high = vin2[sel] + 1 > 2 * code;
   end
endmodule
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top
   import sadc_pkg::*;
;
   logic        clk, rst_n, hsel, hwrite, ext, hrdy, hresp, comp, smp, irq;
   logic [31:0] haddr, hwdata, hrdata, rd, r;
   logic [1:0]  htrans;
   logic [2:0]  ch;
   logic [9:0]  dac;
   int          failures, check_count, cyc;
   time         t0;
   int unsigned vin [8] = '{0, 1, 2046, 2047, 1024, 3, 777, 1500};
   sadc_top DUT (.CLK_SYS(clk), .RESET_N(rst_n), .HSEL(hsel), .HADDR(haddr),
      .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hrdy), .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp),
      .EXTERNAL_START_PIN(ext), .COMP_HIGH(comp), .ANALOG_INPUT_SEL(ch),
      .DAC_CODE(dac), .SAMPLE_EN(smp), .IRQ(irq));
   sadc_ladder_model u_ladder (.sel(ch), .code(dac), .comp_high(comp));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input int d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= SADC_HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hwdata <= 32'(d);
      do @(posedge clk); while (hrdy !== 1'b1);
      rd = hrdata;
   endtask
   // irq rises on the same edge as the done flag; the poll below sees it one cycle later
   task automatic wait_irq();
      for (int k = 0; k < 200 && irq !== 1'b1; k++) @(posedge clk);
      cyc = int'(($time - t0) / 8);
      chk("conv time", 32'(cyc inside {51, 52}), 1);
   endtask
   task automatic chk_res(input string nm, input int unsigned v);
      bus(0, SADC_RESH_ADDR, 0);
      r = rd;
      bus(0, SADC_CTRL_ADDR, 0);
      chk(nm, {r[29:0], rd[7:6]}, v / 2 > 1023 ? 1023 : v / 2);
   endtask
   task automatic finish_test();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #200000;
      failures++;
      finish_test();
   end
   initial begin
      {hsel, hwrite, ext, haddr, hwdata, htrans} = '0;
      {rst_n, failures, check_count} = '0;
      u_ladder.vin2 = vin;
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(0, SADC_CTRL_ADDR, 0);
      chk("ctrl reset", rd, 0);
      bus(0, 8'h20, 0);
      chk("unmapped", rd, 0);
      bus(1, SADC_IRQEN_ADDR, 3);
      for (int i = 0; i < 8; i++) begin
         bus(1, SADC_CTRL_ADDR, i | 8);
         t0 = $time;
         bus(1, SADC_CTRL_ADDR, i | 8);
         chk("channel", 32'(ch), i);
         wait_irq();
         chk_res("result", vin[i]);
         chk("flags", rd[4:0], i | 16);
         bus(1, SADC_CTRL_ADDR, i | 24);
         bus(0, SADC_CTRL_ADDR, 0);
         chk("blocked", rd[4:3], 2);
         bus(1, SADC_IRQCLR_ADDR, 1);
         bus(1, SADC_CTRL_ADDR, i);
         chk("irq clear", irq, 0);
      end
      for (int pd = 1; pd < 3; pd++) begin
         bus(1, SADC_CTRL_ADDR, 8);
         // abort lands in the approximation phase, after a full sample
         repeat (20) @(posedge clk);
         bus(1, SADC_PWR_ADDR, pd); // mid-conversion idle or power-down
         bus(1, SADC_CTRL_ADDR, 8);
         repeat (60) @(posedge clk);
         bus(0, SADC_IRQST_ADDR, 0);
         chk("abort", rd[1:0], 2);
         bus(0, SADC_CTRL_ADDR, 0);
         chk("halted", rd[4:3], 0);
         bus(1, SADC_PWR_ADDR, 0);
         bus(1, SADC_IRQCLR_ADDR, 3);
      end
      bus(1, SADC_AUX_ADDR, 32'h40);
      bus(1, SADC_CTRL_ADDR, 6 | 8);
      t0 = $time;
      bus(1, SADC_PWR_ADDR, 1);
      wait_irq();
      bus(1, SADC_AUX_ADDR, 0);
      repeat (4) @(posedge clk);
      chk_res("kept", vin[6]);
      bus(1, SADC_PWR_ADDR, 0);
      bus(1, SADC_CTRL_ADDR, 0);
      bus(1, SADC_IRQEN_ADDR, 0);
      ext <= 1'b1;
      repeat (3) @(posedge clk);
      bus(0, SADC_CTRL_ADDR, 0);
      chk("no ext", rd[4:3], 0);
      bus(1, SADC_CTRL_ADDR, 32'h25);
      ext <= 1'b0; // low for two machine cycles, then high
      repeat (2) @(posedge clk);
      ext <= 1'b1;
      repeat (2) @(posedge clk);
      bus(0, SADC_CTRL_ADDR, 0);
      chk("ext busy", rd[4:3], 1);
      repeat (60) @(posedge clk);
      chk("masked", irq, 0);
      bus(1, SADC_IRQEN_ADDR, 1);
      repeat (2) @(posedge clk);
      chk("irq on", irq, 1);
      bus(1, SADC_IRQCLR_ADDR, 1);
      repeat (2) @(posedge clk);
      chk("irq off", irq, 0);
      chk_res("ext result", vin[5]);
      finish_test();
   end
endmodule
bind sadc_top sadc_checker u_chk (
   .CLK_SYS          (CLK_SYS),
   .RESET_N          (RESET_N),
   .HSEL             (HSEL),
   .HADDR            (HADDR),
   .HTRANS           (HTRANS),
   .HWRITE           (HWRITE),
   .HREADY           (HREADY),
   .HRDATA           (HRDATA),
   .HREADYOUT        (HREADYOUT),
   .HRESP            (HRESP),
   .ANALOG_INPUT_SEL (ANALOG_INPUT_SEL),
   .DAC_CODE         (DAC_CODE),
   .SAMPLE_EN        (SAMPLE_EN)
);
`default_nettype wire
